// file: apdr_defines.svh
`ifndef APDR_DEFINES_SVH
`define APDR_DEFINES_SVH
// register byte offsets
`define APDR_OFS_CTRL   8'h00
`define APDR_OFS_RATE   8'h04
`define APDR_OFS_QUERY  8'h08
`define APDR_OFS_DATA   8'h0c
`define APDR_OFS_STAT   8'h10
`define APDR_OFS_ERR    8'h14
`define APDR_OFS_FMAX   8'h18
// fields
`define APDR_CTRL_MON   2
`define APDR_CTRL_ARB   3
`define APDR_QRY_KIND   16
`define APDR_RDY_BIT    8
`define APDR_E_CMD      0
`define APDR_E_RATE     1
`define APDR_E_TMO      2
`define APDR_E_SUM      3
`define APDR_E_FM       4
`define APDR_E_AM       5
// values and limits
`define APDR_AW         14
`define APDR_READY_CHR  8'h31
`define APDR_DIV_MAX    32'h007f_ffff
`define APDR_DIV_RST    23'h00_0001
`define APDR_AM_MIN     16'h8000
`define APDR_AM_MAX_PTS 14'd10000
`define APDR_FM_MAX_PTS 14'd1500
`define APDR_PM_MAX_PTS 14'd4000
`define APDR_WP_MAX     14'd16300
`define APDR_WV_MAX     14'd6144
`define APDR_FMAX_RST   32'hffff_ffff
// timing at 200 MHz
`define APDR_CLK_PS     5000
`define APDR_AM_BASE_PS 300000
`define APDR_FM_BASE_PS 2000000
`define APDR_PM_BASE_PS 500000
`define APDR_CYC(ps) ((ps + `APDR_CLK_PS - 1) / `APDR_CLK_PS)
`define APDR_TMO_S      10
`define APDR_TMO_CYC    (`APDR_TMO_S * 200000000)
`endif

// file: apdr_pkg.sv
package apdr_pkg;
	typedef enum logic [1:0] {
		APDR_IDLE = 2'b00,
		APDR_RX   = 2'b01
	} apdr_st_t;
	typedef enum logic [1:0] {
		APDR_AM    = 2'b00,
		APDR_FM    = 2'b01,
		APDR_PM    = 2'b10,
		APDR_OTHER = 2'b11
	} apdr_mt_t;
	typedef enum logic [1:0] {
		APDR_K_MOD  = 2'b00,
		APDR_K_WPT  = 2'b01,
		APDR_K_WVEC = 2'b10,
		APDR_K_BAD  = 2'b11
	} apdr_kind_t;
	typedef struct packed {
		apdr_st_t    st;
		apdr_kind_t  kind;
		apdr_mt_t    qtype;
		logic [13:0] tot;
		logic [13:0] widx;
		logic [1:0]  bidx;
		logic [31:0] word;
		logic [31:0] sum;
		logic [31:0] tmo;
		logic [22:0] div;
		logic [3:0]  ctrl;
		logic [31:0] fmax;
		logic [5:0]  err;
		logic        rdy;
		logic        wbank;
		logic        mbank;
		logic [13:0] wlen;
		logic [13:0] mlen;
		logic        wvec;
		apdr_mt_t    mtype;
		logic        mvalid;
		logic        wvalid;
		logic [13:0] pidx;
		logic [8:0]  bcnt;
		logic [22:0] dcnt;
		logic [31:0] mod_out;
		logic        mod_stb;
		logic        arb_en;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apdr_state_t;
endpackage

// file: apdr_receiver.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "apdr_defines.svh"
module apdr_receiver
	import apdr_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `APDR_TMO_CYC
)
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// waveform table to synthesis datapath
	input  wire logic [13:0] wave_addr,
	output logic      [31:0] wave_data,
	output logic             wave_bank,
	output logic      [13:0] wave_len,
	output logic             wave_vec,
	output logic             arb_out_en,
	// modulation playback
	output logic      [31:0] mod_point,
	output logic             mod_strobe
);
	localparam int unsigned MEMD = 4 * (2 ** `APDR_AW);

	apdr_state_t s_q;
	apdr_state_t s_d;
	logic [31:0] mem [0:MEMD-1];
	logic [31:0] play_rd_q;
	logic [31:0] wave_rd_q;
	logic        mem_we;
	logic [15:0] mem_wa;
	logic [31:0] mem_wd;

	// base cycles of one point per modulation type
	function automatic logic [8:0] base_cyc(input apdr_mt_t t);
		case (t)
			APDR_AM: base_cyc = 9'(`APDR_CYC(`APDR_AM_BASE_PS));
			APDR_FM: base_cyc = 9'(`APDR_CYC(`APDR_FM_BASE_PS));
			APDR_PM: base_cyc = 9'(`APDR_CYC(`APDR_PM_BASE_PS));
			default: base_cyc = 9'(`APDR_CYC(`APDR_AM_BASE_PS));
		endcase
	endfunction

	// largest point count per modulation type
	function automatic logic [13:0] mod_limit(input apdr_mt_t t);
		case (t)
			APDR_AM: mod_limit = `APDR_AM_MAX_PTS;
			APDR_FM: mod_limit = `APDR_FM_MAX_PTS;
			APDR_PM: mod_limit = `APDR_PM_MAX_PTS;
			default: mod_limit = 14'h0000;
		endcase
	endfunction

	// index of last byte of a word: 16-bit for AM and waveform
	function automatic logic [1:0] last_byte(input apdr_kind_t k,
		input apdr_mt_t t);
		if (k == APDR_K_MOD && t != APDR_AM)
			last_byte = 2'h3;
		else
			last_byte = 2'h1;
	endfunction

	// word-width mask for sums
	function automatic logic [31:0] wmask(input logic [1:0] lb);
		if (lb == 2'h3)
			wmask = 32'hffff_ffff;
		else
			wmask = 32'h0000_ffff;
	endfunction

	logic        setup;
	logic        acc;
	logic        byte_in;
	logic        play;
	logic        qok;
	logic [5:0]  eset;
	logic [5:0]  eclr;
	logic [1:0]  lb;
	logic [31:0] w;
	logic [13:0] qcnt;
	apdr_kind_t  qk;
	apdr_mt_t    cmt;

	always_comb
	begin
		s_d = s_q;
		s_d.mod_stb = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		eset = 6'h00;
		eclr = 6'h00;
		mem_we = 1'b0;
		mem_wa = 16'h0000;
		mem_wd = 32'h0000_0000;
		byte_in = 1'b0;
		qok = 1'b0;
		w = 32'h0000_0000;
		setup = psel & ~penable;
		acc = psel & penable & s_q.pready;
		lb = last_byte(s_q.kind, s_q.qtype);
		qcnt = pwdata[13:0];
		qk = apdr_kind_t'(pwdata[`APDR_QRY_KIND+:2]);
		cmt = apdr_mt_t'(s_q.ctrl[1:0]);

		// modulation playback pacing
		play = s_q.ctrl[`APDR_CTRL_MON] & s_q.mvalid
			& (cmt == s_q.mtype);
		if (!play)
		begin
			s_d.bcnt = 9'h000;
			s_d.dcnt = 23'h00_0000;
		end
		else if (s_q.bcnt == base_cyc(s_q.mtype) - 9'h001)
		begin
			s_d.bcnt = 9'h000;
			if (s_q.dcnt == s_q.div - 23'h00_0001)
			begin
				s_d.dcnt = 23'h00_0000;
				s_d.mod_out = play_rd_q;
				s_d.mod_stb = 1'b1;
				if (s_q.pidx == s_q.mlen - 14'h0001)
					s_d.pidx = 14'h0000;
				else
					s_d.pidx = s_q.pidx + 14'h0001;
			end
			else
				s_d.dcnt = s_q.dcnt + 23'h00_0001;
		end
		else
			s_d.bcnt = s_q.bcnt + 9'h001;

		// apb read data prepared in setup phase
		if (setup)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			case (paddr)
				`APDR_OFS_CTRL:  s_d.prdata = {28'h0, s_q.ctrl};
				`APDR_OFS_RATE:  s_d.prdata = {9'h0, s_q.div};
				`APDR_OFS_QUERY: s_d.prdata = {23'h0, s_q.rdy,
					`APDR_READY_CHR};
				`APDR_OFS_DATA:  s_d.prdata = 32'h0000_0000;
				`APDR_OFS_STAT:  s_d.prdata = {28'h0, s_q.wvec,
					s_q.mvalid, s_q.wvalid, s_q.st == APDR_RX};
				`APDR_OFS_ERR:   s_d.prdata = {26'h0, s_q.err};
				`APDR_OFS_FMAX:  s_d.prdata = s_q.fmax;
				default:         s_d.pslverr = 1'b1;
			endcase
		end

		// reading the reply consumes it
		if (acc & ~pwrite & paddr == `APDR_OFS_QUERY)
			s_d.rdy = 1'b0;

		if (acc & pwrite)
		begin
			case (paddr)
				`APDR_OFS_CTRL: s_d.ctrl = pwdata[3:0];
				`APDR_OFS_RATE:
				begin
					if (pwdata != 32'h0 && pwdata <= `APDR_DIV_MAX)
						s_d.div = pwdata[22:0];
					else
						eset[`APDR_E_RATE] = 1'b1;
				end
				`APDR_OFS_QUERY:
				begin
					case (qk)
						APDR_K_MOD: qok = cmt != APDR_OTHER
							&& qcnt != 14'h0
							&& qcnt <= mod_limit(cmt);
						APDR_K_WPT: qok = qcnt != 14'h0
							&& qcnt <= `APDR_WP_MAX;
						APDR_K_WVEC: qok = qcnt != 14'h0
							&& qcnt <= `APDR_WV_MAX;
						default: qok = 1'b0;
					endcase
					if (qok && s_q.st == APDR_IDLE)
					begin
						s_d.st = APDR_RX;
						s_d.kind = qk;
						s_d.qtype = cmt;
						s_d.tot = (qk == APDR_K_WVEC) ?
							{qcnt[12:0], 1'b0} : qcnt;
						s_d.widx = 14'h0000;
						s_d.bidx = 2'h0;
						s_d.word = 32'h0000_0000;
						s_d.sum = 32'h0000_0000;
						s_d.tmo = 32'h0000_0000;
						s_d.rdy = 1'b1;
					end
					else
						eset[`APDR_E_CMD] = 1'b1;
				end
				`APDR_OFS_DATA: byte_in = s_q.st == APDR_RX;
				`APDR_OFS_ERR:  eclr = pwdata[5:0];
				`APDR_OFS_FMAX: s_d.fmax = pwdata;
				default: s_d.pslverr = 1'b0;
			endcase
		end

		// binary payload: bytes build words lsb first
		if (byte_in)
		begin
			s_d.word[8*s_q.bidx+:8] = pwdata[7:0];
			if (s_q.bidx != lb)
				s_d.bidx = s_q.bidx + 2'h1;
			else
			begin
				w = s_d.word & wmask(lb);
				s_d.bidx = 2'h0;
				s_d.word = 32'h0000_0000;
				s_d.tmo = 32'h0000_0000;
				if (s_q.widx != s_q.tot)
				begin
					if (s_q.kind == APDR_K_MOD && s_q.qtype == APDR_AM
						&& w[15:0] == `APDR_AM_MIN)
					begin
						eset[`APDR_E_AM] = 1'b1;
						s_d.st = APDR_IDLE;
					end
					else if (s_q.kind == APDR_K_MOD
						&& s_q.qtype == APDR_FM && w > s_q.fmax)
					begin
						eset[`APDR_E_FM] = 1'b1;
						s_d.st = APDR_IDLE;
					end
					else
					begin
						// spare bank holds the table until it is checked
						mem_we = 1'b1;
						mem_wa = (s_q.kind == APDR_K_MOD) ?
							{1'b1, ~s_q.mbank, s_q.widx} :
							{1'b0, ~s_q.wbank, s_q.widx};
						mem_wd = w;
						s_d.sum = (s_q.sum + w) & wmask(lb);
						s_d.widx = s_q.widx + 14'h0001;
					end
				end
				else
				begin
					s_d.st = APDR_IDLE;
					if (w != s_q.sum)
						eset[`APDR_E_SUM] = 1'b1;
					else if (s_q.kind == APDR_K_MOD)
					begin
						s_d.mbank = ~s_q.mbank;
						s_d.mlen = s_q.tot;
						s_d.mtype = s_q.qtype;
						s_d.mvalid = 1'b1;
						s_d.pidx = 14'h0000;
						s_d.bcnt = 9'h000;
						s_d.dcnt = 23'h00_0000;
					end
					else
					begin
						s_d.wbank = ~s_q.wbank;
						s_d.wlen = s_q.tot;
						s_d.wvec = s_q.kind == APDR_K_WVEC;
						s_d.wvalid = 1'b1;
					end
				end
			end
		end
		else if (s_q.st == APDR_RX)
		begin
			if (s_q.tmo == TIMEOUT_CYC - 32'h1)
			begin
				eset[`APDR_E_TMO] = 1'b1;
				s_d.st = APDR_IDLE;
			end
			else
				s_d.tmo = s_q.tmo + 32'h1;
		end

		// set wins over a clear in the same cycle
		s_d.err = (s_q.err & ~eclr) | eset;
		s_d.arb_en = s_d.ctrl[`APDR_CTRL_ARB] & s_d.wvalid;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.div <= `APDR_DIV_RST;
			s_q.fmax <= `APDR_FMAX_RST;
			s_q.mtype <= APDR_OTHER;
		end
		else
			s_q <= s_d;
	end

	always_ff @(posedge pclk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		play_rd_q <= mem[{1'b1, s_q.mbank, s_q.pidx}];
		wave_rd_q <= mem[{1'b0, s_q.wbank, wave_addr}];
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign wave_data = wave_rd_q;
	assign wave_bank = s_q.wbank;
	assign wave_len = s_q.wlen;
	assign wave_vec = s_q.wvec;
	assign arb_out_en = s_q.arb_en;
	assign mod_point = s_q.mod_out;
	assign mod_strobe = s_q.mod_stb;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_DIV_RANGE: assert property (
		s_q.div != 23'h00_0000)
		else $error("divider left its range");

	AST_REPLY: assert property (
		acc && pwrite && paddr == `APDR_OFS_QUERY && s_q.st == APDR_IDLE
		&& qok |=> s_q.rdy && s_q.st == APDR_RX)
		else $error("accepted query gave no ready reply");

	AST_TMO_BOUND: assert property (
		s_q.st == APDR_RX |-> s_q.tmo < TIMEOUT_CYC)
		else $error("receive timeout overran");

	AST_TMO_ABORT: assert property (
		$rose(s_q.err[`APDR_E_TMO]) |-> s_q.st == APDR_IDLE
		&& $past(s_q.st) == APDR_RX)
		else $error("timeout did not abandon download");

	AST_MOD_TYPE: assert property (
		s_q.st == APDR_IDLE ##1 s_q.st == APDR_RX
		&& s_q.kind == APDR_K_MOD |-> s_q.qtype != APDR_OTHER)
		else $error("pattern accepted with bad modulation type");

	AST_MOD_LIMIT: assert property (
		$changed(s_q.mlen) |-> s_q.mlen <= mod_limit(s_q.mtype))
		else $error("pattern point count over limit");

	AST_WAVE_LIMIT: assert property (
		s_q.wvec ? s_q.wlen <= {`APDR_WV_MAX, 1'b0}
		: s_q.wlen <= `APDR_WP_MAX)
		else $error("waveform length over limit");

	AST_KEEP_OLD: assert property (
		$rose(s_q.err[`APDR_E_SUM]) |-> $stable(s_q.wbank)
		&& $stable(s_q.mbank) && s_q.st == APDR_IDLE)
		else $error("bad checksum changed the live table");

	AST_STROBE_GAP: assert property (
		s_q.mod_stb |=> !s_q.mod_stb [*8])
		else $error("modulation points too close");

	AST_ARB_EN: assert property (
		s_q.arb_en |-> s_q.wvalid && s_q.ctrl[`APDR_CTRL_ARB])
		else $error("arb output enabled without valid table");

	COV_WAVE_OK: cover property ($rose(s_q.wvalid));
	COV_MOD_PLAY: cover property (s_q.mod_stb ##[1:1000] s_q.mod_stb);
	COV_SUM_ERR: cover property ($rose(s_q.err[`APDR_E_SUM]));
	COV_TMO: cover property ($rose(s_q.err[`APDR_E_TMO]));
endmodule

// file: apdr_host.sv
`timescale 1ns/1ps
module apdr_host
(
	// clock
	input  wire logic        pclk,
	// apb master
	output logic      [7:0]  paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int lost = 0;
	initial
	begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
			lost++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines do not keep their old value
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
	task automatic put(input logic [31:0] v, input int nb);
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < nb; i++)
			xfer(1'b1, 8'h0c, {24'h0, v[8*i +: 8]}, r, e);
	endtask
	task automatic load(input logic [1:0] k, input logic [13:0] c,
		input logic [31:0] w [8], input int nw, input int nb, input bit bad);
		logic [31:0] s;
		logic [31:0] r;
		logic        e;
		int          n;
		s = 32'h0;
		n = 0;
		xfer(1'b1, 8'h08, {14'h0, k, 2'h0, c}, r, e);
		xfer(1'b0, 8'h08, 32'h0, r, e);
		while (!(r[8] === 1'b1 && r[7:0] === 8'h31) && n < 16)
		begin
			xfer(1'b0, 8'h08, 32'h0, r, e);
			n++;
		end
		if (n == 16)
			lost++;
		for (int i = 0; i < nw; i++)
		begin
			put(w[i], nb);
			s += w[i];
		end
		if (nb == 2)
			s[31:16] = 16'h0;
		put(s ^ {31'h0, bad}, nb);
	endtask
endmodule

// file: apdr_receiver_tb.sv
`timescale 1ns/1ps
module apdr_receiver_tb;
	import apdr_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic        wave_bank, wave_vec, arb_out_en, mod_strobe;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, wave_data, mod_point;
	logic [13:0] wave_addr, wave_len;
	int          fails = 0;
	int          checked = 0;
	always #2.5 pclk = ~pclk;
	apdr_receiver #(.TIMEOUT_CYC(200)) i_dut
	(
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .wave_addr, .wave_data, .wave_bank,
		.wave_len, .wave_vec, .arb_out_en, .mod_point, .mod_strobe
	);
	apdr_host i_host
	(
		.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr
	);
	task report_and_stop;
		fails += i_host.lost;
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		i_host.xfer(1'b1, a, d, r, e);
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] r;
		logic        e;
		i_host.xfer(1'b0, a, 32'h0, r, e);
		chk(nm, ex, r);
	endtask
	task wstb(output int c);
		c = 0;
		do
		begin
			@(negedge pclk);
			c++;
		end
		while (mod_strobe !== 1'b1 && c < 1000);
		if (c == 1000)
		begin
			fails++;
			report_and_stop;
		end
	endtask
	task t_rate;
		logic [31:0] r;
		logic        e;
		rdchk("rate", 8'h04, 32'h1);
		rdchk("fmax", 8'h18, 32'hffff_ffff);
		rdchk("stat", 8'h10, 32'h0);
		wr(8'h04, 32'h0);
		rdchk("err", 8'h14, 32'h2);
		wr(8'h14, 32'h2);
		wr(8'h04, 32'h0080_0000);
		rdchk("err", 8'h14, 32'h2);
		rdchk("rate", 8'h04, 32'h1);
		wr(8'h14, 32'h2);
		wr(8'h04, 32'h007f_ffff);
		rdchk("rate", 8'h04, 32'h007f_ffff);
		wr(8'h04, 32'h2);
		i_host.xfer(1'b0, 8'h40, 32'h0, r, e);
		chk("slverr", 32'h1, {31'h0, e});
	endtask
	task t_refuse;
		int         lim [5];
		logic [1:0] kd [5];
		lim = '{10000, 1500, 4000, 16300, 6144};
		kd = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
		wr(8'h00, 32'h3);
		wr(8'h08, 32'h2);
		rdchk("err", 8'h14, 32'h1);
		wr(8'h14, 32'h1);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h00, (i < 3) ? i : 0);
			wr(8'h08, {14'h0, kd[i], 2'h0, 14'(lim[i] + 1)});
			rdchk("err", 8'h14, 32'h1);
			wr(8'h14, 32'h1);
		end
	endtask
	task t_play(input logic [1:0] t, input int base, input logic [31:0] m,
		input logic [31:0] w [8], input int n);
		int          c;
		logic [31:0] p;
		bit          hit;
		hit = 0;
		wr(8'h00, {29'h0, 1'b1, t});
		wstb(c);
		p = mod_point & m;
		wstb(c);
		chk("spacing", base * 2, c);
		for (int i = 0; i < n; i++)
			if (p === w[i])
			begin
				hit = 1;
				chk("point", w[(i + 1) % n], mod_point & m);
			end
		chk("found", 32'h1, {31'h0, hit});
		wr(8'h00, {30'h0, t});
	endtask
	task t_mod;
		logic [31:0] wa [8];
		logic [31:0] wp [8];
		wa = '{0:32'h7fff, 1:32'h8001, 2:32'h10, default:32'h0};
		wp = '{0:32'h8000_0000, 1:32'h7fff_ffff, default:32'h0};
		wr(8'h00, 32'h0);
		i_host.load(2'h0, 14'd3, wa, 3, 2, 0);
		rdchk("stat", 8'h10, 32'h4);
		t_play(2'h0, 60, 32'hffff, wa, 3);
		wr(8'h00, 32'h2);
		i_host.load(2'h0, 14'd2, wp, 2, 4, 0);
		rdchk("stat", 8'h10, 32'h4);
		t_play(2'h2, 100, 32'hffff_ffff, wp, 2);
		wr(8'h18, 32'h1000);
		wr(8'h00, 32'h1);
		wp = '{0:32'h2000, default:32'h0};
		i_host.load(2'h0, 14'd2, wp, 2, 4, 0);
		rdchk("err", 8'h14, 32'h10);
		rdchk("stat", 8'h10, 32'h4);
		wr(8'h14, 32'h3f);
		wp = '{0:32'h800, 1:32'h400, default:32'h0};
		i_host.load(2'h0, 14'd2, wp, 2, 4, 0);
		rdchk("stat", 8'h10, 32'h4);
		t_play(2'h1, 400, 32'hffff_ffff, wp, 2);
		wr(8'h00, 32'h0);
		wa = '{0:32'h8000, default:32'h0};
		i_host.load(2'h0, 14'd1, wa, 1, 2, 0);
		rdchk("err", 8'h14, 32'h20);
		rdchk("stat", 8'h10, 32'h4);
		wr(8'h14, 32'h3f);
	endtask
	task t_wave;
		logic [31:0] w [8];
		logic        b;
		w = '{0:32'h07ff, 1:32'hf801, default:32'h0};
		wr(8'h00, 32'h8);
		i_host.load(2'h1, 14'd2, w, 2, 2, 1);
		rdchk("err", 8'h14, 32'h8);
		rdchk("stat", 8'h10, 32'h4);
		chk("arb", 32'h0, {31'h0, arb_out_en});
		wr(8'h14, 32'h8);
		i_host.load(2'h1, 14'd2, w, 2, 2, 0);
		rdchk("stat", 8'h10, 32'h6);
		@(posedge pclk);
		wave_addr <= 14'h1;
		repeat (2) @(negedge pclk);
		chk("arb", 32'h1, {31'h0, arb_out_en});
		chk("len", 32'h2, {18'h0, wave_len});
		chk("data", 32'hf801, {16'h0, wave_data[15:0]});
		b = wave_bank;
		w = '{0:32'h0, 1:32'h5, 2:32'h3, 3:32'h7, default:32'h0};
		i_host.load(2'h2, 14'd2, w, 4, 2, 0);
		rdchk("stat", 8'h10, 32'he);
		chk("len", 32'h4, {18'h0, wave_len});
		chk("vec", 32'h1, {31'h0, wave_vec});
		chk("bank", {31'h0, ~b}, {31'h0, wave_bank});
	endtask
	task t_tmo;
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h2);
		rdchk("query", 8'h08, 32'h131);
		i_host.put(32'h1, 1);
		wr(8'h08, 32'h2);
		rdchk("err", 8'h14, 32'h1);
		wr(8'h14, 32'h1);
		repeat (250) @(posedge pclk);
		rdchk("err", 8'h14, 32'h4);
		rdchk("stat", 8'h10, 32'he);
	endtask
	// a bus wait that ran out ends the run at once
	always @(posedge pclk)
		if (i_host.lost != 0)
			report_and_stop;
	initial
	begin
		presetn = 1'b0;
		wave_addr = 14'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_rate;
		t_refuse;
		t_mod;
		t_wave;
		t_tmo;
		report_and_stop;
	end
endmodule
